//--- verilog/capture_pkg.sv
package capture_pkg;
	// trigger output delay, counted from the edge that samples the probes
	localparam int TRIG_OUT_LATENCY = 10;
	// probe register, match register and event register come before the delay line
	localparam int PIPE_STAGES = 3;
	localparam int MAX_PORTS = 16;
	localparam int MAX_UNITS = 16;
	localparam int MAX_PORT_W = 256;
	localparam int MAX_SAMPLE_W = 4096;

	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] TRIG_MASK_OFS = 12'h008;
	localparam logic [11:0] QUAL_MASK_OFS = 12'h00C;
	localparam logic [11:0] SEQ_LAST_OFS = 12'h010;
	localparam logic [11:0] SEQ_SEL_LO_OFS = 12'h014;
	localparam logic [11:0] SEQ_SEL_HI_OFS = 12'h018;
	localparam logic [11:0] WIN_OFS = 12'h01C;
	localparam logic [11:0] BUF_DATA_OFS = 12'h020;
	// match unit block: paddr[11:8] = 1, unit in paddr[7:4], register in paddr[3:2]
	localparam logic [3:0] MU_PAGE = 4'h1;
	localparam logic [1:0] MU_VALUE_SEL = 2'h0;
	localparam logic [1:0] MU_CARE_SEL = 2'h1;
	localparam logic [1:0] MU_OP_SEL = 2'h2;

	localparam int CTRL_ARM_BIT = 0;
	localparam int CTRL_UPLOAD_BIT = 1;
	localparam int CTRL_SEQ_EN_BIT = 2;
	localparam int CTRL_CONTIG_BIT = 3;
	localparam int CTRL_TRIG_AND_BIT = 4;
	localparam int CTRL_QUAL_EN_BIT = 5;
	localparam int CTRL_QUAL_AND_BIT = 6;
	localparam int CTRL_TOUT_PULSE_BIT = 7;
	localparam int CTRL_TOUT_LOW_BIT = 8;
	localparam int STAT_TRIGGERED_BIT = 4;
	localparam int STAT_LEVEL_POS = 8;
	localparam int STAT_COUNT_POS = 16;
	localparam int WIN_SLICE_POS = 16;

	localparam logic [8:0] CTRL_RESET = 9'h000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [3:0] SEQ_LAST_RESET = 4'h0;
	localparam logic [63:0] SEQ_SEL_RESET = 64'h0000_0000_0000_0000;
	localparam logic [22:0] WIN_RESET = 23'h00_0000;

	typedef enum logic [3:0] {
		OP_EQ = 4'h0,
		OP_NE = 4'h1,
		OP_GT = 4'h2,
		OP_GE = 4'h3,
		OP_LT = 4'h4,
		OP_LE = 4'h5,
		OP_RISE = 4'h6,
		OP_FALL = 4'h7,
		OP_ANY = 4'h8,
		OP_STILL = 4'h9,
		OP_OFF = 4'hF
	} match_op_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ARMED = 4'b0010,
		ST_CAPTURE = 4'b0100,
		ST_FULL = 4'b1000
	} cap_state_e;
endpackage

//--- verilog/match_if.sv
interface match_if #(parameter int W = 8);
	logic [W-1:0] value;
	logic [W-1:0] care;
	logic [W-1:0] probe;
	logic [W-1:0] probe_prev;
	capture_pkg::match_op_e op;
	logic hit;
	modport unit (input value, input care, input probe, input probe_prev, input op, output hit);
	modport core (output value, output care, output probe, output probe_prev, output op, input hit);
endinterface

//--- verilog/match_unit.sv
module match_unit #(
	parameter int W = 8,
	parameter bit HAS_MAG = 1'b1,
	parameter bit HAS_EDGE = 1'b1
)(
	input wire logic clk,
	input wire logic presetn,
	match_if.unit m
);
	logic [W-1:0] a;
	logic [W-1:0] b;
	logic [W-1:0] rose;
	logic [W-1:0] fell;
	logic hit_next;

	// magnitude and edge functions fold to zero when the build leaves them out
	always_comb
	begin
		a = m.probe & m.care;
		b = m.value & m.care;
		rose = m.probe & ~m.probe_prev & m.care;
		fell = ~m.probe & m.probe_prev & m.care;
		hit_next = 1'b0;
		unique case (m.op)
			capture_pkg::OP_EQ: hit_next = (a == b);
			capture_pkg::OP_NE: hit_next = (a != b);
			capture_pkg::OP_GT: hit_next = HAS_MAG && (a > b);
			capture_pkg::OP_GE: hit_next = HAS_MAG && (a >= b);
			capture_pkg::OP_LT: hit_next = HAS_MAG && (a < b);
			capture_pkg::OP_LE: hit_next = HAS_MAG && (a <= b);
			capture_pkg::OP_RISE: hit_next = HAS_EDGE && (|rose);
			capture_pkg::OP_FALL: hit_next = HAS_EDGE && (|fell);
			capture_pkg::OP_ANY: hit_next = HAS_EDGE && (|(rose | fell));
			capture_pkg::OP_STILL: hit_next = HAS_EDGE && !(|(rose | fell));
			capture_pkg::OP_OFF: hit_next = 1'b0;
			// software may write any 4-bit code
			default: hit_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge presetn)
	begin
		if (!presetn)
			m.hit <= 1'b0;
		else
			m.hit <= hit_next;
	end
endmodule

//--- verilog/capture_core.sv
// Function
// - up to sixteen trigger ports, numbered 0 to 15
// - trigger from boolean equation or sequencer
// - cyclical sequencer of up to sixteen levels
// - level advances only on its match event
// - per-level match unit chosen at run time
// - contiguous or non-contiguous advance, run-time choice
// - optional trigger output port
// - trigger output shape and polarity selectable
// - trigger output ten cycles after inputs
// - trigger output cleared on upload or re-arm
// - capture edge rising or falling, build option
// - sample buffer depth is a build option
// - storage qualification gates each stored sample
// - trigger starts capture, qualification picks samples
// - shared mode stores concatenated ports, 4096 max
// - shared mode may exclude ports from samples
// - independent data port, width at most 4096
// - one control path only, rest left free
// - trigger port width 1 to 256 bits
// - 1 to 16 units per port, 16 total
module capture_core #(
	parameter int NUM_PORTS = 2,
	parameter int PORT_W = 8,
	parameter int MU_PER_PORT = 1,
	parameter bit MU_MAGNITUDE = 1'b1,
	parameter bit MU_EDGES = 1'b1,
	parameter int MAX_LEVELS = 16,
	parameter int DEPTH = 1024,
	parameter bit SHARED = 1'b1,
	parameter logic [15:0] EXCLUDE_MASK = 16'h0000,
	parameter int DATA_W = 8,
	parameter bit SAMPLE_FALLING = 1'b0,
	parameter bit TRIG_OUT_EN = 1'b1
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_PORTS*PORT_W-1:0] trig_in,
	input wire logic [DATA_W-1:0] data_in,
	output logic trig_out
);
	localparam int TRIG_W = NUM_PORTS * PORT_W;
	localparam int NUM_MU = NUM_PORTS * MU_PER_PORT;
	localparam int SAMPLE_W = SHARED ? TRIG_W : DATA_W;
	localparam int AW = $clog2(DEPTH);
	localparam int DLY = capture_pkg::TRIG_OUT_LATENCY - capture_pkg::PIPE_STAGES;
	localparam logic [3:0] LVL_MAX = 4'(MAX_LEVELS - 1);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	////////////////////////////////////////////////////////////////////////////
	// register state

	logic [8:0] ctrl_reg;
	logic [15:0] trig_mask_reg;
	logic [15:0] qual_mask_reg;
	logic [3:0] seq_last_reg;
	logic [63:0] seq_sel_reg;
	logic [22:0] win_reg;
	logic [255:0] mu_value_reg [capture_pkg::MAX_UNITS];
	logic [255:0] mu_care_reg [capture_pkg::MAX_UNITS];
	logic [3:0] mu_op_reg [capture_pkg::MAX_UNITS];
	logic arm_reg;
	logic upload_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// capture side
	logic sample_clk;
	logic [TRIG_W-1:0] probe_reg;
	logic [TRIG_W-1:0] probe_prev_reg;
	logic [DATA_W-1:0] data_reg;
	logic [NUM_MU-1:0] hit;
	logic [15:0] hit16;
	logic [SAMPLE_W-1:0] sample;
	logic [SAMPLE_W-1:0] sample_dly_reg;
	logic [SAMPLE_W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW:0] count_reg;
	capture_pkg::cap_state_e state_reg;
	logic [3:0] level_reg;
	logic event_reg;
	logic [DLY-1:0] dly_reg;
	logic held_reg;
	logic trig_out_reg;

	logic [3:0] seq_unit;
	logic seq_adv;
	logic seq_last;
	logic bool_trig;
	logic qual;
	logic trig_cond;
	logic clear;

	////////////////////////////////////////////////////////////////////////////
	// apb slave: setup cycle loads the answer, access cycle shows it

	logic setup;
	logic wr_en;
	logic [3:0] unit;
	logic [6:0] slice;
	logic addr_ok;
	logic [31:0] rd_data;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready_reg & pwrite;
	assign unit = paddr[7:4];
	assign slice = win_reg[capture_pkg::WIN_SLICE_POS +: 7];

	always_comb
	begin
		addr_ok = 1'b1;
		rd_data = 32'h0000_0000;
		if (paddr[11:8] == capture_pkg::MU_PAGE)
		begin
			addr_ok = (32'(unit) < NUM_MU) && (paddr[3:2] != 2'h3) && (paddr[1:0] == 2'h0);
			unique case (paddr[3:2])
				capture_pkg::MU_VALUE_SEL: rd_data = mu_value_reg[unit][slice[2:0]*32 +: 32];
				capture_pkg::MU_CARE_SEL: rd_data = mu_care_reg[unit][slice[2:0]*32 +: 32];
				capture_pkg::MU_OP_SEL: rd_data = 32'(mu_op_reg[unit]);
				default: rd_data = 32'h0000_0000;
			endcase
		end
		else
		begin
			unique case (paddr)
				capture_pkg::CTRL_OFS: rd_data = 32'(ctrl_reg);
				capture_pkg::STATUS_OFS:
					rd_data = 32'(state_reg)
						| (32'(held_reg) << capture_pkg::STAT_TRIGGERED_BIT)
						| (32'(level_reg) << capture_pkg::STAT_LEVEL_POS)
						| (32'(count_reg) << capture_pkg::STAT_COUNT_POS);
				capture_pkg::TRIG_MASK_OFS: rd_data = 32'(trig_mask_reg);
				capture_pkg::QUAL_MASK_OFS: rd_data = 32'(qual_mask_reg);
				capture_pkg::SEQ_LAST_OFS: rd_data = 32'(seq_last_reg);
				capture_pkg::SEQ_SEL_LO_OFS: rd_data = seq_sel_reg[31:0];
				capture_pkg::SEQ_SEL_HI_OFS: rd_data = seq_sel_reg[63:32];
				capture_pkg::WIN_OFS: rd_data = 32'(win_reg);
				capture_pkg::BUF_DATA_OFS:
					rd_data = 32'(mem[win_reg[AW-1:0]] >> (32'(slice) * 32));
				default: addr_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			pready_reg <= setup;
			pslverr_reg <= setup & ~addr_ok;
			if (setup && !pwrite && addr_ok)
				prdata_reg <= rd_data;
			else if (setup)
				prdata_reg <= 32'h0000_0000;
		end
	end

	// the single register port is the one control path; no other chain is consumed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= capture_pkg::CTRL_RESET;
			trig_mask_reg <= capture_pkg::MASK_RESET;
			qual_mask_reg <= capture_pkg::MASK_RESET;
			seq_last_reg <= capture_pkg::SEQ_LAST_RESET;
			seq_sel_reg <= capture_pkg::SEQ_SEL_RESET;
			win_reg <= capture_pkg::WIN_RESET;
		end
		else if (wr_en && addr_ok)
		begin
			unique case (paddr)
				capture_pkg::CTRL_OFS: ctrl_reg <= {pwdata[8:2], 2'b00};
				capture_pkg::TRIG_MASK_OFS: trig_mask_reg <= pwdata[15:0];
				capture_pkg::QUAL_MASK_OFS: qual_mask_reg <= pwdata[15:0];
				capture_pkg::SEQ_LAST_OFS: seq_last_reg <= pwdata[3:0];
				capture_pkg::SEQ_SEL_LO_OFS: seq_sel_reg[31:0] <= pwdata;
				capture_pkg::SEQ_SEL_HI_OFS: seq_sel_reg[63:32] <= pwdata;
				capture_pkg::WIN_OFS: win_reg <= pwdata[22:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < capture_pkg::MAX_UNITS; i++)
			begin
				mu_value_reg[i] <= '0;
				mu_care_reg[i] <= '0;
				mu_op_reg[i] <= capture_pkg::OP_OFF;
			end
		end
		else if (wr_en && addr_ok && paddr[11:8] == capture_pkg::MU_PAGE)
		begin
			unique case (paddr[3:2])
				capture_pkg::MU_VALUE_SEL: mu_value_reg[unit][slice[2:0]*32 +: 32] <= pwdata;
				capture_pkg::MU_CARE_SEL: mu_care_reg[unit][slice[2:0]*32 +: 32] <= pwdata;
				capture_pkg::MU_OP_SEL: mu_op_reg[unit] <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// command pulses last one pclk period, so either sampling edge sees them once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			arm_reg <= 1'b0;
			upload_reg <= 1'b0;
		end
		else
		begin
			arm_reg <= wr_en && paddr == capture_pkg::CTRL_OFS
				&& pwdata[capture_pkg::CTRL_ARM_BIT];
			upload_reg <= wr_en && paddr == capture_pkg::CTRL_OFS
				&& pwdata[capture_pkg::CTRL_UPLOAD_BIT];
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	////////////////////////////////////////////////////////////////////////////
	// probe sampling and match units

	// whole capture pipeline runs on the chosen edge, keeping latency in whole cycles
	assign sample_clk = SAMPLE_FALLING ? ~pclk : pclk;

	// probes are taken as already synchronous, no synchroniser
	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
		begin
			probe_reg <= '0;
			probe_prev_reg <= '0;
			data_reg <= '0;
		end
		else
		begin
			probe_reg <= trig_in;
			probe_prev_reg <= probe_reg;
			data_reg <= data_in;
		end
	end

	// units are grouped per port; unit i watches port i / MU_PER_PORT
	generate
		for (genvar i = 0; i < NUM_MU; i++)
		begin : g_mu
			localparam int P = i / MU_PER_PORT;
			match_if #(.W(PORT_W)) mi ();
			assign mi.probe = probe_reg[P*PORT_W +: PORT_W];
			assign mi.probe_prev = probe_prev_reg[P*PORT_W +: PORT_W];
			assign mi.value = mu_value_reg[i][PORT_W-1:0];
			assign mi.care = mu_care_reg[i][PORT_W-1:0];
			assign mi.op = capture_pkg::match_op_e'(mu_op_reg[i]);
			assign hit[i] = mi.hit;
			match_unit #(
				.W(PORT_W),
				.HAS_MAG(MU_MAGNITUDE),
				.HAS_EDGE(MU_EDGES)
			) u_mu (
				.clk(sample_clk),
				.presetn(presetn),
				.m(mi)
			);
		end
	endgenerate

	always_comb
	begin
		hit16 = 16'h0000;
		hit16[NUM_MU-1:0] = hit;
	end

	////////////////////////////////////////////////////////////////////////////
	// trigger and storage conditions

	assign seq_unit = seq_sel_reg[level_reg*4 +: 4];
	assign seq_adv = hit16[seq_unit];
	assign seq_last = (level_reg >= seq_last_reg) || (level_reg == LVL_MAX);

	// an empty mask never triggers, in either form
	always_comb
	begin
		if (ctrl_reg[capture_pkg::CTRL_TRIG_AND_BIT])
			bool_trig = (&(hit16 | ~trig_mask_reg)) && (|trig_mask_reg);
		else
			bool_trig = |(hit16 & trig_mask_reg);
		if (!ctrl_reg[capture_pkg::CTRL_QUAL_EN_BIT])
			qual = 1'b1;
		else if (ctrl_reg[capture_pkg::CTRL_QUAL_AND_BIT])
			qual = (&(hit16 | ~qual_mask_reg)) && (|qual_mask_reg);
		else
			qual = |(hit16 & qual_mask_reg);
	end

	assign trig_cond = ctrl_reg[capture_pkg::CTRL_SEQ_EN_BIT]
		? (seq_adv && seq_last) : bool_trig;
	assign clear = arm_reg | upload_reg;

	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
			level_reg <= 4'h0;
		else if (arm_reg || state_reg != capture_pkg::ST_ARMED)
			level_reg <= 4'h0;
		else if (ctrl_reg[capture_pkg::CTRL_SEQ_EN_BIT])
		begin
			if (seq_adv)
				level_reg <= seq_last ? 4'h0 : level_reg + 4'h1;
			else if (ctrl_reg[capture_pkg::CTRL_CONTIG_BIT])
				level_reg <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// capture state and sample buffer

	// shared mode: excluded ports store as zero
	always_comb
	begin
		if (SHARED)
		begin
			sample = SAMPLE_W'(probe_reg);
			for (int p = 0; p < NUM_PORTS; p++)
				if (EXCLUDE_MASK[p])
					sample[p*PORT_W +: PORT_W] = '0;
		end
		else
			sample = SAMPLE_W'(data_reg);
	end

	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
			sample_dly_reg <= '0;
		else
			sample_dly_reg <= sample;
	end

	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= capture_pkg::ST_IDLE;
		else if (arm_reg)
			state_reg <= capture_pkg::ST_ARMED;
		else if (upload_reg)
			state_reg <= capture_pkg::ST_IDLE;
		else
		begin
			unique case (state_reg)
				capture_pkg::ST_IDLE: ;
				capture_pkg::ST_ARMED:
					if (trig_cond)
						state_reg <= capture_pkg::ST_CAPTURE;
				capture_pkg::ST_CAPTURE:
					if (qual && wr_ptr_reg == PTR_LAST)
						state_reg <= capture_pkg::ST_FULL;
				capture_pkg::ST_FULL: ;
				default: state_reg <= capture_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr_reg <= '0;
			count_reg <= '0;
		end
		else if (arm_reg)
		begin
			wr_ptr_reg <= '0;
			count_reg <= '0;
		end
		else if (state_reg == capture_pkg::ST_CAPTURE && qual)
		begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
			count_reg <= count_reg + 1'b1;
		end
	end

	// buffer has no reset; contents stay readable after upload
	always_ff @(posedge sample_clk)
	begin
		if (state_reg == capture_pkg::ST_CAPTURE && qual && !arm_reg)
			mem[wr_ptr_reg] <= sample_dly_reg;
	end

	////////////////////////////////////////////////////////////////////////////
	// trigger output: event, delay line, shaped output flop

	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
			event_reg <= 1'b0;
		else
			event_reg <= state_reg == capture_pkg::ST_ARMED && trig_cond && !clear;
	end

	// probe, match and event stages plus this line give the fixed latency
	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
			dly_reg <= '0;
		else
			dly_reg <= {dly_reg[DLY-2:0], event_reg};
	end

	// a trigger arriving with the clear still latches
	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
			held_reg <= 1'b0;
		else if (dly_reg[DLY-1])
			held_reg <= 1'b1;
		else if (clear)
			held_reg <= 1'b0;
	end

	always_ff @(posedge sample_clk or negedge presetn)
	begin
		if (!presetn)
			trig_out_reg <= 1'b0;
		else if (!TRIG_OUT_EN)
			trig_out_reg <= 1'b0;
		else
			trig_out_reg <= ctrl_reg[capture_pkg::CTRL_TOUT_LOW_BIT]
				^ (dly_reg[DLY-1] || (held_reg && !clear
				&& !ctrl_reg[capture_pkg::CTRL_TOUT_PULSE_BIT]));
	end

	assign trig_out = trig_out_reg;
endmodule

//--- verification/capture_checker.sv
module capture_checker #(
	parameter int NUM_PORTS = 2,
	parameter int PORT_W = 8,
	parameter int DATA_W = 8
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_PORTS*PORT_W-1:0] trig_in,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic trig_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pulse_reg;
	logic low_reg;
	logic [3:0] quiet_reg;
	logic [5:0] since_arm_reg;
	wire logic ctrl_wr = psel && penable && pready && pwrite && paddr == capture_pkg::CTRL_OFS;
	// polarity folded out, so one property serves both senses
	wire logic active = trig_out ^ low_reg;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pulse_reg <= 1'h0;
			low_reg <= 1'h0;
			quiet_reg <= 4'hF;
			since_arm_reg <= 6'h3F;
		end
		else
		begin
			if (ctrl_wr)
			begin
				pulse_reg <= pwdata[7];
				low_reg <= pwdata[8];
			end
			quiet_reg <= ctrl_wr ? 4'h0 : (quiet_reg == 4'hF ? quiet_reg : quiet_reg + 4'h1);
			if (ctrl_wr && pwdata[0])
				since_arm_reg <= 6'h00;
			else if (since_arm_reg != 6'h3F)
				since_arm_reg <= since_arm_reg + 6'h01;
		end
	end
	////////////////////////////////////////////////////////////////
	chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready) else $error("pready missing after setup");
	chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready) else $error("pready longer than one cycle");
	chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready && prdata == 32'h0000_0000) else $error("pslverr alone or with data");
	chk_write_data_zero: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && pwrite |=> prdata == 32'h0000_0000) else $error("prdata on write");
	chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && paddr == 12'h024 |=> pslverr) else $error("unmapped not refused");
	chk_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
		!pulse_reg && quiet_reg > 4'h2 && active |=> active) else $error("level output dropped");
	chk_pulse_single: assert property (@(posedge pclk) disable iff (!presetn)
		pulse_reg && quiet_reg > 4'h2 && active |=> !active) else $error("pulse too long");
	chk_trig_latency: assert property (@(posedge pclk) disable iff (!presetn)
		quiet_reg > 4'h3 && !$past(active) && active |-> since_arm_reg >= 6'h0A)
		else $error("trigger output too early after arm");
endmodule

bind capture_core capture_checker #(
	.NUM_PORTS(NUM_PORTS),
	.PORT_W(PORT_W),
	.DATA_W(DATA_W)
) i_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.trig_in(trig_in),
	.data_in(data_in),
	.trig_out(trig_out)
);

//--- verification/probe_source.sv
module probe_source (
	input wire logic pclk,
	input wire logic presetn,
	output logic [15:0] trig_in,
	output logic [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] hold = 16'h0000;
	// unused data keeps moving so a stale value is never mistaken for a sample
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trig_in <= 16'h0000;
			data_in <= 8'hA5;
		end
		else
		begin
			trig_in <= hold;
			data_in <= ~data_in;
		end
	end
endmodule

//--- verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trig_out, rd_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [15:0] trig_in;
	logic [7:0] data_in;
	int n_errors = 0;
	int n_tests = 0;
	// one core on this control path, nothing left unconnected
	capture_core #(.DEPTH(16)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trig_in(trig_in), .data_in(data_in),
		.trig_out(trig_out));
	probe_source i_probe (.pclk(pclk), .presetn(presetn), .trig_in(trig_in), .data_in(data_in));
	////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end
	task test_done;
		$display("comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// request stands until the edge that samples pready high; answer taken at that edge
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: no pready", $time);
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask
	task rd_chk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
		xfer(1'h0, a, 32'h0000_0000);
		check(rd_data & mask, exp, "register read");
	endtask
	task mu_set(input logic [3:0] u, input logic [7:0] v, input capture_pkg::match_op_e op);
		wr({capture_pkg::MU_PAGE, u, capture_pkg::MU_VALUE_SEL, 2'h0}, {24'h00_0000, v});
		wr({capture_pkg::MU_PAGE, u, capture_pkg::MU_CARE_SEL, 2'h0}, 32'h0000_00FF);
		wr({capture_pkg::MU_PAGE, u, capture_pkg::MU_OP_SEL, 2'h0}, {28'h000_0000, op});
	endtask
	task probe(input logic [15:0] v);
		@(posedge pclk);
		i_probe.hold <= v;
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		rd_chk(capture_pkg::CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(capture_pkg::STATUS_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
		rd_chk(12'h118, 32'hFFFF_FFFF, 32'h0000_000F);
		xfer(1'h0, 12'h024, 32'h0000_0000);
		check({31'h0000_0000, rd_err}, 32'h0000_0001, "unmapped read");
		check(rd_data, 32'h0000_0000, "unmapped data");
		wr(12'h120, 32'h0000_0001);
		check({31'h0000_0000, rd_err}, 32'h0000_0001, "absent unit");
		wr(capture_pkg::STATUS_OFS, 32'hFFFF_FFFF);
		rd_chk(capture_pkg::STATUS_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
		$display("test reset done");
	endtask
	task t_bool;
		int k;
		mu_set(4'h0, 8'h5A, capture_pkg::OP_EQ);
		wr(capture_pkg::TRIG_MASK_OFS, 32'h0000_0001);
		wr(capture_pkg::CTRL_OFS, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		probe(16'h005A);
		probe(16'h0000);
		#1;
		k = 1;
		while (trig_out !== 1'h1 && k < 30)
		begin
			@(posedge pclk);
			#1;
			k++;
		end
		check(k, 12, "trigger latency");
		rd_data = 32'h0000_0000;
		for (int i = 0; i < 10 && rd_data[3] !== 1'h1; i++)
			xfer(1'h0, capture_pkg::STATUS_OFS, 32'h0000_0000);
		check(rd_data, 32'h0010_0018, "full after depth");
		check({31'h0000_0000, trig_out}, 32'h0000_0001, "level kept");
		wr(capture_pkg::CTRL_OFS, 32'h0000_0002);
		repeat (3) @(posedge pclk);
		#1;
		check({31'h0000_0000, trig_out}, 32'h0000_0000, "cleared by upload");
		rd_chk(capture_pkg::STATUS_OFS, 32'h0000_000F, 32'h0000_0001);
		$display("test boolean trigger done");
	endtask
	task t_seq;
		int k;
		mu_set(4'h1, 8'h33, capture_pkg::OP_EQ);
		wr(capture_pkg::SEQ_LAST_OFS, 32'h0000_0001);
		wr(capture_pkg::SEQ_SEL_LO_OFS, 32'h0000_0001);
		wr(capture_pkg::CTRL_OFS, 32'h0000_0185);
		probe(16'h005A);
		probe(16'h0000);
		repeat (3) @(posedge pclk);
		rd_chk(capture_pkg::STATUS_OFS, 32'h0000_0F1F, 32'h0000_0002);
		probe(16'h3300);
		probe(16'h0000);
		repeat (8) @(posedge pclk);
		rd_chk(capture_pkg::STATUS_OFS, 32'h0000_0F1F, 32'h0000_0102);
		probe(16'h005A);
		probe(16'h0000);
		k = 0;
		for (int i = 0; i < 30; i++)
		begin
			@(posedge pclk);
			#1;
			k += (trig_out === 1'h0);
		end
		check(k, 1, "active low pulse");
		rd_chk(capture_pkg::STATUS_OFS, 32'h0000_0010, 32'h0000_0010);
		$display("test sequencer done");
	endtask
	task t_contig;
		wr(capture_pkg::CTRL_OFS, 32'h0000_000D);
		probe(16'h3300);
		probe(16'h0000);
		probe(16'h005A);
		probe(16'h0000);
		repeat (14) @(posedge pclk);
		rd_chk(capture_pkg::STATUS_OFS, 32'h0000_0F10, 32'h0000_0000);
		check({31'h0000_0000, trig_out}, 32'h0000_0000, "no trigger on gap");
		probe(16'h3300);
		probe(16'h005A);
		probe(16'h0000);
		repeat (14) @(posedge pclk);
		rd_chk(capture_pkg::STATUS_OFS, 32'h0000_0010, 32'h0000_0010);
		$display("test contiguous done");
	endtask
	task t_qual;
		wr(capture_pkg::QUAL_MASK_OFS, 32'h0000_0002);
		wr(capture_pkg::CTRL_OFS, 32'h0000_0021);
		repeat (3) @(posedge pclk);
		#1;
		check({31'h0000_0000, trig_out}, 32'h0000_0000, "cleared by re-arm");
		probe(16'h33FF);
		probe(16'h005A);
		probe(16'h0000);
		probe(16'h0000);
		for (int i = 1; i < 4; i++)
		begin
			probe(16'h3300 + 16'(i));
			probe(16'h0000);
		end
		repeat (4) @(posedge pclk);
		rd_chk(capture_pkg::STATUS_OFS, 32'h001F_001F, 32'h0003_0014);
		for (int i = 0; i < 3; i++)
		begin
			wr(capture_pkg::WIN_OFS, 32'(i));
			rd_chk(capture_pkg::BUF_DATA_OFS, 32'hFFFF_FFFF, 32'h0000_3301 + 32'(i));
		end
		$display("test qualification done");
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		t_bool;
		t_seq;
		t_contig;
		t_qual;
		test_done;
	end
	// whole run is a few hundred cycles, so this only trips on a hang
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		test_done;
	end
endmodule
